// >>> logic/fefh_pkg.sv
package fefh_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG  = 8'h00; // Media, forced link, code en
   localparam logic [7:0] ADDR_STATUS  = 8'h04; // Link and fault status
   localparam logic [7:0] ADDR_ADVERT  = 8'h08; // Local remote-fault advert
   localparam logic [7:0] ADDR_PARTNER = 8'h0C; // Partner ability bits
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h10; // Sticky event flags
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h14; // Event mask

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CFG_FIBER     = 0;  // Fiber media select
   localparam int CFG_CODE_EN   = 2;  // Fault code transmission enable
   localparam int CFG_LOOPBACK  = 3;  // Loopback enable
   localparam int CFG_FORCE_LNK = 14; // Forced link pass
   localparam int ST_FAULT      = 4;  // Latched fault, clear on read
   localparam int ST_LINK       = 2;  // Link up
   localparam int ADV_RFAULT    = 13; // Local remote-fault flag
   localparam int LP_RFAULT     = 13; // Partner remote-fault flag
   localparam int IRQ_LINK_DOWN = 0;  // Link dropped
   localparam int IRQ_FAULT     = 1;  // Fault latched
   localparam int IRQ_W         = 2;

   // ---------------------------------------------------------------
   // Pattern and timing constants
   // ---------------------------------------------------------------
   localparam logic [6:0] FAR_END_FAULT_INDICATION_ONES    = 7'h54; // 84 ones per instance
   localparam logic [1:0] FAR_END_FAULT_INDICATION_MIN_REP = 2'h3;  // Least repetitions
   localparam logic [1:0] IDLE_NEEDED  = 2'h2;  // Idle cycles before link
   localparam logic [8:0] FAR_END_FAULT_INDICATION_MIN_CYC = 9'h0FF; // Least pattern cycles

   // Line output symbol selection
   typedef enum logic [1:0] {
      LINE_IDLE,
      LINE_DATA,
      LINE_FAR_END_FAULT_INDICATION,
      LINE_PULSE
   } fefh_line_type;

   // APB request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } fefh_apb_req_type;

   // Line output carrier
   typedef struct packed {
      fefh_line_type kind;
      logic          bit_val;
   } fefh_line_out_type;

endpackage

// >>> logic/fefh_top.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module fefh_top
   import fefh_pkg::*;
(
   input  wire logic                       mclk,          // 40 MHz clock
   input  wire logic                       rst,           // Sync reset, high
   input  wire fefh_pkg::fefh_apb_req_type apb_req,       // APB request
   output logic [31:0]                     prdata,        // APB read data
   output logic                            pready,        // APB ready
   output logic                            pslverr,       // APB error
   input  wire logic                       signal_detect_media_select, // Pin
   input  wire logic                       pll_locked,    // Receive PLL lock
   input  wire logic                       an_active,     // Negotiation busy
   input  wire logic                       an_rx_rfault,  // Partner fault
   input  wire logic                       rx_idle,       // Idle received
   input  wire logic                       rx_far_end_fault_indication,       // Fault pattern rx
   input  wire logic                       mac_tx_en,     // MAC sending
   input  wire logic                       mac_tx_bit,    // MAC data bit
   output fefh_pkg::fefh_line_out_type     line_out,      // Line symbol
   output logic                            link_up,       // Link status
   output logic                            irq            // Interrupt level
);
   import fefh_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic               fiber_q;
   logic               code_en_q;
   logic               loop_q;
   logic               force_q;
   logic               adv_rf_q;
   logic               lp_rf_q;
   logic               fault_q;
   logic               link_q;
   logic               idle_seen_q;
   logic [1:0]         idle_cnt_q;
   logic               strap_q;
   logic [IRQ_W-1:0]   irq_st_q;
   logic [IRQ_W-1:0]   irq_msk_q;
   logic [31:0]        prdata_q;
   logic               pready_q;
   logic               pslverr_q;
   logic               irq_q;
   fefh_line_out_type  line_q;
   logic [6:0]         bit_cnt_q;
   logic [1:0]         rep_cnt_q;
   logic [8:0]         far_end_fault_indication_len_q;

   typedef enum logic [1:0] {
      TX_NORMAL,
      TX_FAR_END_FAULT_INDICATION
   } fefh_tx_type;
   fefh_tx_type tx_state_q;

   logic wr_acc;
   logic rd_acc;
   logic addr_ok;
   logic fiber_sd;
   logic local_fault;
   logic remote_fault;
   logic any_fault;
   logic far_end_fault_indication_cond;
   logic link_d;
   logic link_fall;
   logic status_rd;
   logic pat_end;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Access phase handshake, answered in the first access cycle
   assign wr_acc  = apb_req.psel & apb_req.penable & apb_req.pwrite
                    & pready_q;
   assign rd_acc  = apb_req.psel & apb_req.penable & ~apb_req.pwrite
                    & pready_q;
   assign addr_ok = (apb_req.paddr == ADDR_CONFIG)
                    | (apb_req.paddr == ADDR_STATUS)
                    | (apb_req.paddr == ADDR_ADVERT)
                    | (apb_req.paddr == ADDR_PARTNER)
                    | (apb_req.paddr == ADDR_IRQ_ST)
                    | (apb_req.paddr == ADDR_IRQ_MSK);
   assign status_rd = rd_acc & (apb_req.paddr == ADDR_STATUS);

   // Ready rises in the first access cycle, so each access takes one wait-free cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= apb_req.psel & ~apb_req.penable;
         pslverr_q <= apb_req.psel & ~apb_req.penable & ~addr_ok;
      end
   end

   // Read data mux, registered in the setup cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_req.psel & ~apb_req.penable) begin
         prdata_q <= 32'h0000_0000;
         case (apb_req.paddr)
            ADDR_CONFIG: begin
               prdata_q[CFG_FIBER]     <= fiber_q;
               prdata_q[CFG_CODE_EN]   <= code_en_q;
               prdata_q[CFG_LOOPBACK]  <= loop_q;
               prdata_q[CFG_FORCE_LNK] <= force_q;
            end
            ADDR_STATUS: begin
               prdata_q[ST_FAULT] <= fault_q;
               prdata_q[ST_LINK]  <= link_q;
            end
            ADDR_ADVERT:  prdata_q[ADV_RFAULT] <= adv_rf_q;
            ADDR_PARTNER: prdata_q[LP_RFAULT]  <= lp_rf_q;
            ADDR_IRQ_ST:  prdata_q[IRQ_W-1:0]  <= irq_st_q;
            ADDR_IRQ_MSK: prdata_q[IRQ_W-1:0]  <= irq_msk_q;
            default:      prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   // Strap is caught on the first clock after reset release
   always_ff @(posedge mclk) begin
      strap_q <= rst;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fiber_q   <= 1'b0;
         code_en_q <= 1'b0;
         loop_q    <= 1'b0;
         force_q   <= 1'b0;
         adv_rf_q  <= 1'b0;
      end else if (strap_q) begin
         fiber_q <= signal_detect_media_select;
      end else if (wr_acc & (apb_req.paddr == ADDR_CONFIG)) begin
         fiber_q   <= apb_req.pwdata[CFG_FIBER];
         code_en_q <= apb_req.pwdata[CFG_CODE_EN];
         loop_q    <= apb_req.pwdata[CFG_LOOPBACK];
         force_q   <= apb_req.pwdata[CFG_FORCE_LNK];
      end else if (wr_acc & (apb_req.paddr == ADDR_ADVERT)) begin
         adv_rf_q <= apb_req.pwdata[ADV_RFAULT];
      end
   end

   // ---------------------------------------------------------------
   // Fault detection
   // ---------------------------------------------------------------
   // Shared pin as signal detect
   assign fiber_sd     = fiber_q & ~strap_q & signal_detect_media_select;
   assign local_fault  = fiber_q & ~strap_q & (~fiber_sd | ~pll_locked);
   assign remote_fault = an_active & ~fiber_q & an_rx_rfault;
   assign any_fault    = local_fault | remote_fault;

   always_ff @(posedge mclk) begin
      if (rst) begin
         lp_rf_q <= 1'b0;
      end else if (remote_fault) begin
         lp_rf_q <= 1'b1;
      end
   end

   // Fault bit, set wins over read clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         fault_q <= 1'b0;
      end else if (any_fault) begin
         fault_q <= 1'b1;
      end else if (status_rd) begin
         fault_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Link state
   // ---------------------------------------------------------------
   // Idles must come before link in fiber
   always_ff @(posedge mclk) begin
      if (rst) begin
         idle_cnt_q  <= 2'h0;
         idle_seen_q <= 1'b0;
      end else if (!fiber_sd || (rx_far_end_fault_indication && !idle_seen_q)) begin
         idle_cnt_q  <= 2'h0;
         idle_seen_q <= 1'b0;
      end else if (rx_idle && !idle_seen_q) begin
         idle_cnt_q  <= idle_cnt_q + 2'h1;
         idle_seen_q <= (idle_cnt_q + 2'h1) == IDLE_NEEDED;
      end
   end

   // Drop link on fault unless forced
   always_comb begin
      if (force_q) begin
         link_d = 1'b1;
      end else if (any_fault || strap_q) begin
         link_d = 1'b0;
      end else if (fiber_q) begin
         link_d = idle_seen_q;
      end else begin
         link_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         link_q <= 1'b0;
      end else begin
         link_q <= link_d;
      end
   end

   assign link_fall = link_q & ~link_d;

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // Link down and fault events, set wins over write-one clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_st_q <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_LINK_DOWN && link_fall)
                || (i == IRQ_FAULT && any_fault && !fault_q)) begin
               irq_st_q[i] <= 1'b1;
            end else if (wr_acc && apb_req.paddr == ADDR_IRQ_ST
                         && apb_req.pwdata[i]) begin
               irq_st_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_msk_q <= '0;
      end else if (wr_acc & (apb_req.paddr == ADDR_IRQ_MSK)) begin
         irq_msk_q <= apb_req.pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_st_q & irq_msk_q);
      end
   end

   // ---------------------------------------------------------------
   // Transmit path
   // ---------------------------------------------------------------
   // Fault code conditions
   assign far_end_fault_indication_cond = fiber_q & code_en_q & local_fault & ~loop_q;
   assign pat_end   = (bit_cnt_q == FAR_END_FAULT_INDICATION_ONES);

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_state_q <= TX_NORMAL;
         bit_cnt_q  <= 7'h00;
         rep_cnt_q  <= 2'h0;
      end else begin
         case (tx_state_q)
            TX_NORMAL: begin
               if (far_end_fault_indication_cond) begin
                  tx_state_q <= TX_FAR_END_FAULT_INDICATION;
                  bit_cnt_q  <= 7'h00;
                  rep_cnt_q  <= 2'h0;
               end
            end
            TX_FAR_END_FAULT_INDICATION: begin
               if (pat_end) begin
                  bit_cnt_q <= 7'h00;
                  if (rep_cnt_q != FAR_END_FAULT_INDICATION_MIN_REP) begin
                     rep_cnt_q <= rep_cnt_q + 2'h1;
                  end
                  if (((rep_cnt_q + 2'h1) >= FAR_END_FAULT_INDICATION_MIN_REP
                       || rep_cnt_q == FAR_END_FAULT_INDICATION_MIN_REP) && !far_end_fault_indication_cond) begin
                     tx_state_q <= TX_NORMAL;
                  end
               end else begin
                  bit_cnt_q <= bit_cnt_q + 7'h01;
               end
            end
            default: tx_state_q <= TX_NORMAL;
         endcase
      end
   end

   // Cycles in the pattern state, checked by the repeat assertion
   always_ff @(posedge mclk) begin
      if (rst || tx_state_q != TX_FAR_END_FAULT_INDICATION) begin
         far_end_fault_indication_len_q <= 9'h000;
      end else if (far_end_fault_indication_len_q != 9'h1FF) begin
         far_end_fault_indication_len_q <= far_end_fault_indication_len_q + 9'h001;
      end
   end

   // Idle or link pulses when no data
   always_ff @(posedge mclk) begin
      if (rst) begin
         line_q <= '{kind: LINE_IDLE, bit_val: 1'b0};
      end else if (tx_state_q == TX_FAR_END_FAULT_INDICATION) begin
         line_q <= '{kind: LINE_FAR_END_FAULT_INDICATION, bit_val: ~pat_end};
      end else if (mac_tx_en && link_q) begin
         line_q <= '{kind: LINE_DATA, bit_val: mac_tx_bit};
      end else if (!fiber_q && !link_q) begin
         line_q <= '{kind: LINE_PULSE, bit_val: 1'b0};
      end else begin
         line_q <= '{kind: LINE_IDLE, bit_val: 1'b1};
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign line_out = line_q;
   assign link_up  = link_q;
   assign irq      = irq_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_far_end_fault_indication_start;
      tx_state_q == TX_NORMAL && far_end_fault_indication_cond;
   endsequence
   sequence s_far_end_fault_indication_leave;
      tx_state_q == TX_FAR_END_FAULT_INDICATION ##1 tx_state_q == TX_NORMAL;
   endsequence

   a_fault_latch: assert property (@(posedge mclk) disable iff (rst)
      any_fault |=> fault_q)
      else $error("fault bit not latched");

   a_read_clear: assert property (@(posedge mclk) disable iff (rst)
      (status_rd && !any_fault) |=> !fault_q)
      else $error("fault bit not cleared by read");

   a_fault_drops_link: assert property (
      @(posedge mclk) disable iff (rst) (any_fault && !force_q) |=> !link_up)
      else $error("link kept up during fault");

   a_forced_link: assert property (@(posedge mclk) disable iff (rst)
      force_q |=> link_up)
      else $error("forced link not up");

   a_no_code_off: assert property (@(posedge mclk) disable iff (rst)
      (!code_en_q && tx_state_q == TX_NORMAL)[*2] |=>
         line_out.kind != LINE_FAR_END_FAULT_INDICATION)
      else $error("fault code with enable clear");

   a_pattern_zero: assert property (@(posedge mclk) disable iff (rst)
      (s_far_end_fault_indication_start ##1 1'b1) |-> ##85 line_out.bit_val == 1'b0)
      else $error("pattern zero bit misplaced");

   a_three_repeats: assert property (@(posedge mclk) disable iff (rst)
      s_far_end_fault_indication_leave |-> far_end_fault_indication_len_q >= FAR_END_FAULT_INDICATION_MIN_CYC)
      else $error("fewer than three patterns");

   a_link_irq: assert property (@(posedge mclk) disable iff (rst)
      link_fall |=> irq_st_q[IRQ_LINK_DOWN])
      else $error("link drop not flagged");

   a_partner_bit: assert property (@(posedge mclk) disable iff (rst)
      remote_fault |=> lp_rf_q)
      else $error("partner bit not set");

endmodule

// >>> test/fefh_link_partner.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Fiber module and far partner
// ---------------------------------------------------------------
module fefh_link_partner
   import fefh_pkg::*;
(
   input  wire logic                    mclk,       // Clock
   input  wire logic                    rst,        // Sync reset
   input  wire logic                    sd_level,   // Optical signal seen
   input  wire logic [1:0]              rx_mode,    // 0 quiet 1 idle 2 fault
   input  wire fefh_pkg::fefh_line_out_type line_in, // Symbols we receive
   output logic                         sd_pin,     // Shared select pin
   output logic                         rx_idle,    // Idle decoded
   output logic                         rx_far_end_fault_indication,    // Fault pattern decoded
   output logic [7:0]                   far_end_fault_indication_cnt_q, // Whole patterns seen
   output logic                         far_end_fault_indication_bad_q  // Broken pattern seen
);
   logic [6:0] ones_q;

   // Signal detect and decoded receive symbols
   assign sd_pin  = sd_level;
   assign rx_idle = (rx_mode == 2'h1);
   assign rx_far_end_fault_indication = (rx_mode == 2'h2);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ones_q     <= 7'h00;
         far_end_fault_indication_cnt_q <= 8'h00;
         far_end_fault_indication_bad_q <= 1'b0;
      end else if (line_in.kind != LINE_FAR_END_FAULT_INDICATION) begin
         ones_q <= 7'h00;
      end else if (line_in.bit_val) begin
         ones_q <= (ones_q == 7'h7f) ? ones_q : ones_q + 7'h01;
      end else begin
         if (ones_q == FAR_END_FAULT_INDICATION_ONES)
            far_end_fault_indication_cnt_q <= far_end_fault_indication_cnt_q + 8'h01;
         else
            far_end_fault_indication_bad_q <= 1'b1;
         ones_q <= 7'h00;
      end
   end
endmodule

// >>> test/fefh_top_tb_top.sv
`timescale 1ns/1ps
module fefh_top_tb_top;
   import fefh_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              mclk;
   logic              rst;
   fefh_apb_req_type  apb_req;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              sd_pin;
   logic              pll_locked;
   logic              an_active;
   logic              an_rx_rfault;
   logic              rx_idle;
   logic              rx_far_end_fault_indication;
   logic              mac_tx_en;
   logic              mac_tx_bit;
   fefh_line_out_type line_out;
   logic              link_up;
   logic              irq;
   logic              sd_level;
   logic [1:0]        rx_mode;
   logic [7:0]        far_end_fault_indication_cnt;
   logic              far_end_fault_indication_bad;
   logic [31:0]       rd_d;
   logic              slv_q;
   int                err_total;
   int                check_count;
   int                h;
   logic              l;

   fefh_top dut (.mclk(mclk), .rst(rst), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .signal_detect_media_select(sd_pin), .pll_locked(pll_locked),
      .an_active(an_active), .an_rx_rfault(an_rx_rfault),
      .rx_idle(rx_idle), .rx_far_end_fault_indication(rx_far_end_fault_indication), .mac_tx_en(mac_tx_en),
      .mac_tx_bit(mac_tx_bit), .line_out(line_out), .link_up(link_up),
      .irq(irq));

   fefh_link_partner fiber (.mclk(mclk), .rst(rst), .sd_level(sd_level),
      .rx_mode(rx_mode), .line_in(line_out), .sd_pin(sd_pin),
      .rx_idle(rx_idle), .rx_far_end_fault_indication(rx_far_end_fault_indication), .far_end_fault_indication_cnt_q(far_end_fault_indication_cnt),
      .far_end_fault_indication_bad_q(far_end_fault_indication_bad));

   // Clock and a toggling MAC bit stream
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) mac_tx_bit <= ~mac_tx_bit;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // One APB transfer, request held until pready is sampled at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      apb_req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         err_total++;
         give_verdict();
      end
      rd_d = prdata;
      slv_q = pslverr;
      apb_req <= '0;
   endtask

   task automatic do_reset(input logic strap);
      @(posedge mclk);
      rst <= 1'b1;
      sd_level <= strap;
      rx_mode <= 2'h0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   // Wait until the line kind matches, or stops matching
   task automatic wait_kind(input fefh_line_type k, input logic eq,
                            input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(negedge mclk);
         if ((line_out.kind === k) == eq) break;
      end
      if (n == lim) begin
         err_total++;
         give_verdict();
      end
      @(posedge mclk);
   endtask

   // Optical signal lost for len cycles; counts fault symbols meanwhile
   task automatic fault_run(input int len, output int hits,
                            output logic lnk);
      hits = 0;
      @(posedge mclk);
      sd_level <= 1'b0;
      repeat (len) begin
         @(negedge mclk);
         if (line_out.kind === LINE_FAR_END_FAULT_INDICATION) hits++;
      end
      lnk = link_up;
      @(posedge mclk);
      sd_level <= 1'b1;
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0; rst = 1'b1; apb_req = '0; sd_level = 1'b0;
      rx_mode = 2'h0; pll_locked = 1'b1; an_active = 1'b0;
      an_rx_rfault = 1'b0; mac_tx_en = 1'b0; mac_tx_bit = 1'b0;
      err_total = 0; check_count = 0;
      do_reset(1'b0);
      apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
      chk(rd_d[CFG_FIBER], 1'b0);
      chk(line_out.kind inside {LINE_IDLE, LINE_PULSE}, 1'b1);
      apb(1'b1, ADDR_ADVERT, 32'h0000_2000);
      apb(1'b0, ADDR_ADVERT, 32'h0000_0000);
      chk(rd_d, 32'h0000_2000);
      an_rx_rfault <= 1'b1;
      repeat (5) @(posedge mclk);
      apb(1'b0, ADDR_PARTNER, 32'h0000_0000);
      chk(rd_d, 32'h0000_0000);
      an_active <= 1'b1;
      repeat (5) @(posedge mclk);
      an_active <= 1'b0;
      an_rx_rfault <= 1'b0;
      apb(1'b0, ADDR_PARTNER, 32'h0000_0000);
      chk(rd_d, 32'h0000_2000);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd_d[ST_FAULT], 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd_d[ST_FAULT], 1'b0);
      apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
      apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
      chk(rd_d, 32'h0000_0001);
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      chk(slv_q, 1'b1);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk(rd_d, 32'h0000_0000);
      chk(slv_q, 1'b1);
      // Fiber strap, fault pattern first
      do_reset(1'b1);
      apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
      chk(rd_d[CFG_FIBER], 1'b1);
      rx_mode <= 2'h2;
      repeat (10) @(posedge mclk);
      chk(link_up, 1'b0);
      apb(1'b0, ADDR_IRQ_ST, 32'h0000_0000);
      chk(rd_d, 32'h0000_0000);
      do_reset(1'b1);
      rx_mode <= 2'h1;
      repeat (10) @(posedge mclk);
      chk(link_up, 1'b1);
      mac_tx_en <= 1'b1;
      wait_kind(LINE_DATA, 1'b1, 10);
      apb(1'b1, ADDR_CONFIG, 32'h0000_0005);
      fault_run(10, h, l);
      mac_tx_en <= 1'b0;
      chk(h > 0, 1'b1);
      chk(l, 1'b0);
      wait_kind(LINE_FAR_END_FAULT_INDICATION, 1'b0, 400);
      chk(far_end_fault_indication_cnt >= 8'h03, 1'b1);
      chk(far_end_fault_indication_bad, 1'b0);
      chk(line_out.kind, LINE_IDLE);
      chk(irq, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd_d[ST_FAULT], 1'b1);
      apb(1'b0, ADDR_IRQ_ST, 32'h0000_0000);
      chk(rd_d[IRQ_LINK_DOWN], 1'b1);
      // Receive lock lost alone also sends the pattern
      pll_locked <= 1'b0;
      wait_kind(LINE_FAR_END_FAULT_INDICATION, 1'b1, 20);
      pll_locked <= 1'b1;
      wait_kind(LINE_FAR_END_FAULT_INDICATION, 1'b0, 400);
      chk(far_end_fault_indication_bad, 1'b0);
      chk(far_end_fault_indication_cnt, 8'h06);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, ADDR_IRQ_ST, 32'h0000_0003);
      apb(1'b0, ADDR_IRQ_ST, 32'h0000_0000);
      chk(rd_d, 32'h0000_0000);
      apb(1'b1, ADDR_IRQ_MSK, 32'h0000_0003);
      apb(1'b1, ADDR_CONFIG, 32'h0000_000D);
      fault_run(10, h, l);
      chk(h, 0);
      chk(irq, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, ADDR_IRQ_ST, 32'h0000_0003);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      // Code off with forced link pass
      apb(1'b1, ADDR_CONFIG, 32'h0000_4001);
      repeat (5) @(posedge mclk);
      fault_run(10, h, l);
      chk(h, 0);
      chk(l, 1'b1);
      give_verdict();
   end
endmodule
